// >>> rtl/adcst_pkg.sv
/*
 * Package for the converter serial timing block: timing figures, derived
 * cycle counts, widths and the sequencer states.
 * Assumes a core clock of 25 MHz.
 */
package adcst_pkg;
	localparam int CLK_MHZ = 25;
	localparam int RESULT_W = 16;
	localparam int CFG_W = 14;
	localparam int FIFO_DEPTH = 16;
	// Conversion time limits in nanoseconds, high and low supply range.
	localparam int CONV_HI_NS = 2200;
	localparam int CONV_LO_NS = 3200;
	// Longest times round down to whole cycles.
	localparam int CONV_HI_CYC = (CONV_HI_NS * CLK_MHZ) / 1000;
	localparam int CONV_LO_CYC = (CONV_LO_NS * CLK_MHZ) / 1000;
	// Worst-case cycles from a pin rise to the sequencer's start.
	localparam int SYNC_CYC = 4;
	// Last counter value of a conversion. The synchroniser's delay is taken
	// off, so the slot closes within the limit as seen from the pin.
	localparam int CONV_HI_LIM = CONV_HI_CYC - 1 - SYNC_CYC;
	localparam int CONV_LO_LIM = CONV_LO_CYC - 1 - SYNC_CYC;
	localparam int CNT_W = 8;
	localparam logic [3:0] BIT_IDX_RST = 4'hf;
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
	typedef enum logic [1:0] {
		ADCST_IDLE,
		ADCST_CONV,
		ADCST_DONE
	} adcst_state_t;
endpackage

// >>> rtl/adcst_fifo_if.sv
/*
 * Interface carrying the write and read sides of the sample FIFO.
 * Assumes both sides sit on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface adcst_fifo_if;
	logic [15:0] wr_data;
	logic wr_valid;
	logic wr_ready;
	logic [15:0] rd_data;
	logic rd_valid;
	logic rd_ready;
	modport fifo (input wr_data, input wr_valid, output wr_ready,
		output rd_data, output rd_valid, input rd_ready);
	modport user (output wr_data, output wr_valid, input wr_ready,
		input rd_data, input rd_valid, output rd_ready);
endinterface
`default_nettype wire

// >>> rtl/adcst_fifo.sv
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module adcst_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic rst_b,
	adcst_fifo_if.fifo port
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic do_wr;
	logic do_rd;

	assign port.wr_ready = (cnt_q != (AW+1)'(DEPTH));
	assign port.rd_valid = (cnt_q != '0);
	assign port.rd_data = mem[rp_q];
	assign do_wr = port.wr_valid && port.wr_ready;
	assign do_rd = port.rd_valid && port.rd_ready;

	always_ff @(posedge core_clk)
	begin
		if (do_wr)
			mem[wp_q] <= port.wr_data;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (do_wr)
				wp_q <= wp_q + 1'b1;
			if (do_rd)
				rp_q <= rp_q + 1'b1;
			if (do_wr && !do_rd)
				cnt_q <= cnt_q + 1'b1;
			else if (do_rd && !do_wr)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // adcst_fifo
`default_nettype wire

// >>> rtl/adcst_top.sv
/*
 * Conversion sequencer and serial port of a 16-bit sampling converter.
 * Assumes conversion_start, serial clock and serial data input come from
 * pins outside the core clock domain; the converted samples arrive on a
 * plain sample port from the analogue side and wait in a FIFO.
 */
`timescale 1ns/1ps
`default_nettype none
// How it works
// RL1: Result ready within conversion time limit.
// RL2: Host keeps transfers during conversion short.
// RL3: Top bit driven when conversion_start falls; the code drives it only when no conversion is running.
// RL4: Next bit shifted on serial clock fall.
// RL5: Configuration bits captured on serial rise.
// RL6: Output released on start high or end.
// RL7: Host waits before first serial rise.
// RL8: Sixteen-bit binary or twos complement result; the code passes the sample unchanged in both modes.
// RL9: Result readable right after conversion ends.
// RL10: Host gives sixteen clocks per read.
module adcst_top (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic conversion_start,
	input wire logic serial_clk,
	input wire logic serial_data_in,
	input wire logic low_supply,
	input wire logic bipolar_mode,
	input wire logic [15:0] sample_data,
	input wire logic sample_valid,
	output logic sample_ready,
	output logic serial_result_out,
	output logic serial_result_oe,
	output logic [13:0] config_word,
	output logic config_valid,
	output logic conv_busy
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] cnv_s_q;
	logic [2:0] sck_s_q;
	logic [2:0] din_s_q;
	logic cnv_lvl_q;
	logic sck_lvl_q;
	logic cnv_rise;
	logic cnv_fall;
	logic sck_rise;
	logic sck_fall;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnv_s_q <= 3'h0;
			sck_s_q <= 3'h0;
			din_s_q <= 3'h0;
		end
		else
		begin
			cnv_s_q <= {cnv_s_q[1:0], conversion_start};
			sck_s_q <= {sck_s_q[1:0], serial_clk};
			din_s_q <= {din_s_q[1:0], serial_data_in};
		end
	end

	// A level counts only once stages two and three agree.
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnv_lvl_q <= 1'b0;
			sck_lvl_q <= 1'b0;
		end
		else
		begin
			if (cnv_s_q[1] == cnv_s_q[2])
				cnv_lvl_q <= cnv_s_q[2];
			if (sck_s_q[1] == sck_s_q[2])
				sck_lvl_q <= sck_s_q[2];
		end
	end

	assign cnv_rise = (cnv_s_q[1] == cnv_s_q[2]) && cnv_s_q[2] && !cnv_lvl_q;
	assign cnv_fall = (cnv_s_q[1] == cnv_s_q[2]) && !cnv_s_q[2] && cnv_lvl_q;
	assign sck_rise = (sck_s_q[1] == sck_s_q[2]) && sck_s_q[2] && !sck_lvl_q;
	assign sck_fall = (sck_s_q[1] == sck_s_q[2]) && !sck_s_q[2] && sck_lvl_q;

	// ------------------------------------------------------------
	// Sample FIFO
	// ------------------------------------------------------------
	adcst_fifo_if fif ();
	adcst_fifo #(
		.WIDTH(adcst_pkg::RESULT_W),
		.DEPTH(adcst_pkg::FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.port(fif)
	);
	assign fif.wr_data = sample_data;
	assign fif.wr_valid = sample_valid;
	assign sample_ready = fif.wr_ready;

	// ------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------
	adcst_pkg::adcst_state_t state_q;
	logic [adcst_pkg::CNT_W-1:0] conv_cnt_q;
	logic [adcst_pkg::CNT_W-1:0] conv_lim;
	logic [15:0] result_q;
	logic take;

	assign conv_lim = low_supply ?
		adcst_pkg::CNT_W'(adcst_pkg::CONV_LO_LIM) :
		adcst_pkg::CNT_W'(adcst_pkg::CONV_HI_LIM);
	// The result is taken in the first conversion cycle with a sample waiting,
	// which ends the conversion; a late sample is taken if it shows up before the time limit.
	assign take = (state_q == adcst_pkg::ADCST_CONV) && fif.rd_valid; // RL9
	assign fif.rd_ready = take;
	assign conv_busy = (state_q == adcst_pkg::ADCST_CONV);

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= adcst_pkg::ADCST_IDLE;
			conv_cnt_q <= adcst_pkg::CNT_RST;
		end
		else
		begin
			case (state_q)
				adcst_pkg::ADCST_IDLE:
				begin
					conv_cnt_q <= adcst_pkg::CNT_RST;
					if (cnv_rise)
						state_q <= adcst_pkg::ADCST_CONV;
				end
				adcst_pkg::ADCST_CONV:
				begin
					conv_cnt_q <= conv_cnt_q + 1'b1;
					// Without a sample the old result stays; the slot closes on time.
					if (take || conv_cnt_q >= conv_lim) // RL1
						state_q <= adcst_pkg::ADCST_DONE;
				end
				adcst_pkg::ADCST_DONE:
				begin
					if (cnv_rise)
						state_q <= adcst_pkg::ADCST_CONV;
					conv_cnt_q <= adcst_pkg::CNT_RST;
				end
				default:
					state_q <= adcst_pkg::ADCST_IDLE;
			endcase
		end
	end

	// Bipolar and unipolar modes both pass the FIFO sample through unchanged.
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			result_q <= 16'h0000;
		else if (take)
			result_q <= bipolar_mode ? fif.rd_data :
				{fif.rd_data[15], fif.rd_data[14:0]}; // RL8
	end

	// ------------------------------------------------------------
	// Serial shifter
	// ------------------------------------------------------------
	logic [15:0] shift_q;
	logic [3:0] bit_idx_q;
	logic oe_q;
	logic out_q;
	logic [13:0] cfg_sh_q;
	logic [3:0] cfg_cnt_q;
	logic [13:0] cfg_q;
	logic cfg_v_q;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			shift_q <= 16'h0000;
			bit_idx_q <= adcst_pkg::BIT_IDX_RST;
			oe_q <= 1'b0;
			out_q <= 1'b0;
		end
		else if (cnv_rise)
		begin
			oe_q <= 1'b0; // RL6
			bit_idx_q <= adcst_pkg::BIT_IDX_RST;
		end
		else if (cnv_fall && state_q != adcst_pkg::ADCST_CONV)
		begin
			shift_q <= result_q;
			out_q <= result_q[15]; // RL3
			oe_q <= 1'b1;
			bit_idx_q <= adcst_pkg::BIT_IDX_RST;
		end
		else if (sck_fall && oe_q)
		begin
			if (bit_idx_q == 4'h0)
				oe_q <= 1'b0; // RL6
			else
			begin
				out_q <= shift_q[bit_idx_q - 4'h1]; // RL4
				bit_idx_q <= bit_idx_q - 4'h1;
			end
		end
	end

	assign serial_result_out = out_q;
	assign serial_result_oe = oe_q;

	// Configuration shift-in; a frame opens on conversion_start falling.
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg_sh_q <= 14'h0000;
			cfg_cnt_q <= 4'h0;
			cfg_q <= 14'h0000;
			cfg_v_q <= 1'b0;
		end
		else
		begin
			cfg_v_q <= 1'b0;
			if (cnv_fall)
				cfg_cnt_q <= 4'h0;
			else if (sck_rise && !cnv_lvl_q && cfg_cnt_q != 4'he)
			begin
				cfg_sh_q <= {cfg_sh_q[12:0], din_s_q[2]}; // RL5
				cfg_cnt_q <= cfg_cnt_q + 4'h1;
				if (cfg_cnt_q == 4'hd)
				begin
					cfg_q <= {cfg_sh_q[12:0], din_s_q[2]};
					cfg_v_q <= 1'b1;
				end
			end
		end
	end

	assign config_word = cfg_q;
	assign config_valid = cfg_v_q;
endmodule // adcst_top
`default_nettype wire

// >>> bench/adcst_top_properties.sv
/* Port checker for adcst_top, bound to it below.
   Assumes pins change on the core clock grid. */
`timescale 1ns/1ps
`default_nettype none
module adcst_top_properties (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic conversion_start,
	input wire logic serial_clk,
	input wire logic low_supply,
	input wire logic sample_valid,
	input wire logic sample_ready,
	input wire logic serial_result_out,
	input wire logic serial_result_oe,
	input wire logic config_valid,
	input wire logic conv_busy
);
	logic sck_q, cnv_q;
	logic [4:0] fall_q, rise_q;
	logic [3:0] age_q;
	logic [7:0] busy_q;
	wire logic fell_w = sck_q && !serial_clk;
	wire logic open_w = cnv_q && !conversion_start;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{sck_q, cnv_q, fall_q, rise_q, busy_q} <= '0;
			age_q <= 4'hf;
		end
		else
		begin
			sck_q <= serial_clk;
			cnv_q <= conversion_start;
			busy_q <= (conversion_start && !cnv_q) ? 8'h00 :
				busy_q + {7'h0, busy_q != 8'hff};
			age_q <= fell_w ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
			fall_q <= open_w ? 5'h00 : fall_q + {4'h0, fell_w};
			rise_q <= open_w ? 5'h00 : rise_q + {4'h0, serial_clk && !sck_q};
		end
	end
	// Busy is timed from the pin's rise, so the synchroniser delay counts.
	time_lim_a:
		assert property (conv_busy |-> busy_q < (low_supply ?
			adcst_pkg::CONV_LO_CYC : adcst_pkg::CONV_HI_CYC))
		else $error("conversion too long");
	busy_rise_a:
		assert property ($rose(conversion_start) |-> ##[1:6] conv_busy)
		else $error("conversion not started");
	early_done_a:
		assert property (conv_busy && sample_valid && sample_ready
			|-> ##[1:4] !conv_busy)
		else $error("sample not taken at once");
	top_bit_a:
		assert property ($fell(conversion_start) && !conv_busy
			|-> ##[1:6] serial_result_oe)
		else $error("output not driven");
	shift_fall_a:
		assert property (serial_result_oe && $past(serial_result_oe)
			&& $changed(serial_result_out) && fall_q != 5'h00
			|-> age_q <= 4'h6)
		else $error("bit moved away from a fall");
	oe_end_a:
		assert property (fall_q == 5'h10 && age_q == 4'h7
			|-> !serial_result_oe)
		else $error("output held after last fall");
	oe_abort_a:
		assert property ($rose(conversion_start) |-> ##[1:6] !serial_result_oe)
		else $error("output held after start");
	cfg_count_a:
		assert property (config_valid |-> rise_q >= 5'h0e)
		else $error("config taken too early");
	cover property ($fell(conv_busy));
	cover property (fall_q == 5'h10);
	cover property (config_valid);
endmodule // adcst_top_properties
bind adcst_top adcst_top_properties chk_u (.*);
`default_nettype wire

// >>> bench/adcst_host_model.sv
/* Host controller model for the serial port.
   Assumes it shares the core clock with the bench. */
`timescale 1ns/1ps
`default_nettype none
module adcst_host_model (
	input wire logic core_clk,
	input wire logic serial_result_out,
	input wire logic serial_result_oe,
	output logic conversion_start,
	output logic serial_clk,
	output logic serial_data_in
);
	logic bit_v;
	initial
	begin
		{conversion_start, serial_clk, serial_data_in, bit_v} = 4'h0;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic start();
		conversion_start = 1'b1;
		tick(1);
	endtask
	// Callers open a frame only after busy falls. A released line shows
	// the inverse of its last bit, since nothing pulls it.
	task automatic read(input int n, input logic [13:0] cfg, input int lo,
		output logic [15:0] res);
		res = 16'h0000;
		conversion_start = 1'b0;
		tick(6);
		for (int i = 0; i < n; i++)
		begin
			serial_data_in = i < 14 ? cfg[13 - i] : 1'b1;
			tick(lo);
			serial_clk = 1'b1;
			tick(4);
			bit_v = serial_result_oe ? serial_result_out : !bit_v;
			res = {res[14:0], bit_v};
			serial_clk = 1'b0;
			tick(2);
		end
		serial_data_in = !serial_data_in;
	endtask
endmodule // adcst_host_model
`default_nettype wire

// >>> bench/adcst_top_tb_top.sv
/* Self-checking bench for adcst_top.
   Assumes the package, FIFO and host model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module adcst_top_tb_top;
	logic core_clk, rst_b, conversion_start, serial_clk, serial_data_in;
	logic low_supply, bipolar_mode, sample_valid, sample_ready;
	logic serial_result_out, serial_result_oe, config_valid, conv_busy;
	logic [15:0] sample_data, res;
	logic [13:0] config_word;
	int fails, total_checks, n;
	int cfg_seen = 0;
	adcst_top dut_u (.*);
	adcst_host_model host_u (.*);
	always @(posedge core_clk)
		if (config_valid === 1'b1)
			cfg_seen++;
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = !core_clk;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input string s, input logic [15:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wait_busy(input logic lvl);
		n = 0;
		while (conv_busy !== lvl)
		begin
			tick(1);
			n++;
			if (n > 300)
			begin
				fails++;
				report_and_stop();
			end
		end
	endtask
	task automatic conv(input logic low, input logic [13:0] cfg,
		input logic [15:0] exp);
		int m;
		int c;
		low_supply = low;
		host_u.start();
		wait_busy(1'b1);
		m = n;
		wait_busy(1'b0);
		// Cycles counted from the pin's rise, one tick before the first wait.
		n = n + m + 1;
		c = cfg_seen;
		host_u.read(16, cfg, 2, res);
		check("result", exp, res);
		tick(6);
		check("oe after frame", 16'h0000, {15'h0, serial_result_oe});
		check("config", {2'h0, cfg}, {2'h0, config_word});
		check("config pulses", 16'h0001, 16'(cfg_seen - c));
	endtask
	task automatic sc_fill_drain();
		for (int i = 0; i < 17; i++)
		begin
			sample_data = 16'(i) * 16'h1111;
			sample_valid = 1'b1;
			tick(1);
		end
		sample_valid = 1'b0;
		check("ready when full", 16'h0000, {15'h0, sample_ready});
		for (int i = 0; i < 16; i++)
		begin
			bipolar_mode = i[0];
			conv(i[1], 14'h2aaa ^ 14'(i), 16'(i) * 16'h1111);
		end
	endtask
	task automatic sc_timeout();
		int lim;
		for (int i = 0; i < 2; i++)
		begin
			lim = i ? adcst_pkg::CONV_LO_CYC : adcst_pkg::CONV_HI_CYC;
			conv(i[0], 14'h3fff - 14'(i), 16'hffff);
			check("busy time", 16'h0001, {15'h0, n >= lim - 2 && n <= lim});
		end
	endtask
	task automatic sc_early_abort();
		host_u.start();
		wait_busy(1'b1);
		tick(10);
		sample_data = 16'h8001;
		sample_valid = 1'b1;
		tick(1);
		sample_valid = 1'b0;
		wait_busy(1'b0);
		check("early end", 16'h0001, {15'h0, n < 6});
		host_u.read(16, 14'h0155, 2, res);
		check("early result", 16'h8001, res);
		host_u.start();
		wait_busy(1'b1);
		wait_busy(1'b0);
		host_u.read(15, 14'h0aaa, 2, res);
		check("partial read", 16'h4000, res);
		host_u.start();
		tick(6);
		check("oe on abort", 16'h0000, {15'h0, serial_result_oe});
		check("config on abort", 16'h0aaa, {2'h0, config_word});
		wait_busy(1'b0);
	endtask
	initial
	begin
		{rst_b, low_supply, bipolar_mode, sample_valid} = 4'h0;
		sample_data = 16'h0000;
		fails = 0;
		total_checks = 0;
		tick(8);
		rst_b = 1'b1;
		tick(2);
		sc_fill_drain();
		sc_timeout();
		sc_early_abort();
		report_and_stop();
	end
endmodule // adcst_top_tb_top
`default_nettype wire
